/* File: src/rra_pkg.sv */
// constants and types for the remote access and fault report block
// assumes a single 250 MHz clock and a synchronous command port
package rra_pkg;
   localparam int NSET = 14;
   localparam int NGRP = 3;
   localparam logic [1:0] GRP_ACTIVE = 2'h0;
   localparam logic [1:0] GRP_MAIN = 2'h1;
   localparam logic [1:0] GRP_SECOND = 2'h2;
   localparam logic [15:0] SET_MIN = 16'h0000;
   localparam logic [15:0] SET_MAX = 16'h03E7;
   localparam logic [15:0] SET_RST = 16'h0000;
   localparam logic [9:0] PWD_MIN = 10'h001;
   localparam logic [9:0] PWD_MAX = 10'h3E7;
   localparam logic [9:0] PWD_RST = 10'h001;
   localparam logic [15:0] FMT_VALUE = 16'h0002;
   localparam logic [1:0] STAT_RESET_BIT = 2'h1;
   localparam logic [1:0] STAT_OVF_BIT = 2'h2;
   localparam logic [7:0] FC_NONE = 8'h00;
   localparam logic [7:0] FC_POWER = 8'h01;
   localparam logic [7:0] FC_TRIP = 8'h04;
   localparam logic [7:0] FC_ROM = 8'h1E;
   localparam logic [7:0] FC_RAM = 8'h32;
   localparam logic [7:0] FC_PAR_BASE = 8'h33;
   localparam logic [7:0] FC_KEY = 8'h38;
   localparam logic [7:0] FC_LOW_X1 = 8'hC3;
   localparam logic [7:0] FC_LOW_X5 = 8'h83;
   localparam logic [7:0] FC_LOW_X25 = 8'h43;
   localparam logic [7:0] FC_HIGH_X1 = 8'hCB;
   localparam logic [7:0] FC_HIGH_X5 = 8'h8B;
   localparam logic [7:0] FC_HIGH_X25 = 8'h4B;
   localparam logic [7:0] FC_ADC = 8'hFD;
   localparam logic [3:0] FC_LEAD_DIGIT = 4'h1;
   localparam int CLK_MHZ = 250;
   localparam int IRF_DELAY_NS = 100;
   localparam int IRF_DELAY_CYC = (IRF_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] IRF_DELAY = 8'(IRF_DELAY_CYC);
   typedef enum logic [3:0] {
      RRA_CMD_NONE = 4'b0000,
      RRA_CMD_READ_EV = 4'b0001,
      RRA_CMD_REREAD_EV = 4'b0010,
      RRA_CMD_READ_STAT = 4'b0011,
      RRA_CMD_CLR_STAT = 4'b0100,
      RRA_CMD_READ_SET = 4'b0101,
      RRA_CMD_WRITE_SET = 4'b0110,
      RRA_CMD_OPEN_PWD = 4'b0111,
      RRA_CMD_CHG_PWD = 4'b1000,
      RRA_CMD_FORMAT = 4'b1001,
      RRA_CMD_READ_FAULT = 4'b1010
   } rra_cmd_e;
   typedef enum logic [2:0] {
      RRA_FT_NONE = 3'b000,
      RRA_FT_REF_LOW = 3'b001,
      RRA_FT_REF_HIGH = 3'b010
   } rra_ref_e;
endpackage : rra_pkg

/* File: src/rra_core.sv */
// remote access, event delivery and self-supervision fault reporting
// assumes one command per cycle from the partner, inputs synchronous
`timescale 1ns/1ps
module rra_core
   import rra_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic cmd_valid,
   input wire rra_cmd_e cmd_code,
   input wire logic [1:0] cmd_group,
   input wire logic [3:0] cmd_index,
   input wire logic [15:0] cmd_wdata,
   input wire logic local_wr,
   input wire logic [1:0] local_group,
   input wire logic [3:0] local_index,
   input wire logic [15:0] local_wdata,
   input wire logic ev_valid,
   input wire logic [31:0] ev_data,
   input wire logic auto_reset,
   input wire logic flt_trip_path,
   input wire logic flt_rom,
   input wire logic flt_ram,
   input wire logic [3:0] flt_par_mem,
   input wire logic flt_par_key,
   input wire logic [1:0] ref_fault,
   input wire logic [1:0] ref_mult,
   input wire logic flt_adc,
   input wire logic power_reset,
   output logic rsp_valid_ff,
   output logic [31:0] rsp_data_ff,
   output logic rsp_err_ff,
   output logic pwd_open_ff,
   output logic [1:0] status_ff,
   output logic internal_fault_indicator_ff,
   output logic supervision_out_ff,
   output logic [3:0] fault_lead_ff,
   output logic [7:0] fault_num_ff
);
   logic [15:0] set_mem [NGRP][NSET];
   logic [31:0] ev_reg_ff;
   logic ev_full_ff;
   logic [31:0] ev_last_ff;
   logic [9:0] pwd_ff;
   logic [7:0] irf_cnt_ff;
   logic [7:0] nxt_fault;
   logic fault_perm;
   logic take_read;
   logic rem_wr;
   logic rem_ok;
   logic loc_ok;
   logic fmt_ok;
   logic idx_ok;

   assign take_read = cmd_valid && cmd_code == RRA_CMD_READ_EV;
   assign idx_ok = 32'(cmd_index) < NSET && 32'(cmd_group) < NGRP;
   // one write path for all three groups
   assign rem_wr = cmd_valid && cmd_code == RRA_CMD_WRITE_SET;
   assign rem_ok = rem_wr && pwd_open_ff && idx_ok
      && cmd_wdata >= SET_MIN && cmd_wdata <= SET_MAX;
   assign loc_ok = local_wr && 32'(local_index) < NSET
      && 32'(local_group) < NGRP
      && local_wdata >= SET_MIN && local_wdata <= SET_MAX;
   assign fmt_ok = cmd_valid && cmd_code == RRA_CMD_FORMAT && pwd_open_ff
      && cmd_wdata == FMT_VALUE;

   // remote write wins a collision with a panel write
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int g = 0; g < NGRP; g++) begin
            for (int i = 0; i < NSET; i++) begin
               set_mem[g][i] <= SET_RST;
            end
         end
      end else if (rem_ok) begin
         set_mem[cmd_group][cmd_index] <= cmd_wdata;
      end else if (loc_ok) begin
         set_mem[local_group][local_index] <= local_wdata;
      end
   end

   // single event slot; a new event while full and not read that cycle is dropped, old kept
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ev_full_ff <= 1'b0;
         ev_reg_ff <= '0;
      end else if (ev_valid && (!ev_full_ff || take_read)) begin
         ev_full_ff <= 1'b1;
         ev_reg_ff <= ev_data;
      end else if (take_read) begin
         ev_full_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ev_last_ff <= '0;
      end else if (take_read) begin
         ev_last_ff <= ev_full_ff ? ev_reg_ff : '0;
      end
   end

   // set beats clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         status_ff <= '0;
      end else begin
         status_ff <= ((cmd_valid && cmd_code == RRA_CMD_CLR_STAT
            && cmd_wdata == 16'h0000) ? 2'h0 : status_ff)
            | (auto_reset ? STAT_RESET_BIT : 2'h0)
            | (ev_valid && ev_full_ff && !take_read
               ? STAT_OVF_BIT : 2'h0);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pwd_ff <= PWD_RST;
         pwd_open_ff <= 1'b0;
      end else if (cmd_valid && cmd_code == RRA_CMD_OPEN_PWD) begin
         pwd_open_ff <= cmd_wdata[9:0] == pwd_ff
            && cmd_wdata[15:10] == '0;
      end else if (cmd_valid && cmd_code == RRA_CMD_CHG_PWD
            && pwd_open_ff) begin
         if (cmd_wdata == 16'h0000) begin
            pwd_open_ff <= 1'b0;
         end else if (cmd_wdata <= 16'(PWD_MAX)
               && cmd_wdata >= 16'(PWD_MIN)) begin
            pwd_ff <= cmd_wdata[9:0];
         end
      end
   end

   // key fault stays until a format clears it
   logic key_flt_ff;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         key_flt_ff <= 1'b0;
      end else if (flt_par_key) begin
         key_flt_ff <= 1'b1;
      end else if (fmt_ok) begin
         key_flt_ff <= 1'b0;
      end
   end

   // fixed priority picks one fault number when several are present
   always_comb begin
      nxt_fault = FC_NONE;
      if (flt_adc) begin
         nxt_fault = FC_ADC;
      end else if (ref_fault == 2'(RRA_FT_REF_LOW)) begin
         case (ref_mult)
            2'h0: nxt_fault = FC_LOW_X1;
            2'h1: nxt_fault = FC_LOW_X5;
            default: nxt_fault = FC_LOW_X25;
         endcase
      end else if (ref_fault == 2'(RRA_FT_REF_HIGH)) begin
         case (ref_mult)
            2'h0: nxt_fault = FC_HIGH_X1;
            2'h1: nxt_fault = FC_HIGH_X5;
            default: nxt_fault = FC_HIGH_X25;
         endcase
      end else if (flt_rom) begin
         nxt_fault = FC_ROM;
      end else if (flt_ram) begin
         nxt_fault = FC_RAM;
      end else if (key_flt_ff) begin
         nxt_fault = FC_KEY;
      end else if (flt_par_mem != 4'h0) begin
         for (int k = 3; k >= 0; k--) begin
            if (flt_par_mem[k]) begin
               nxt_fault = FC_PAR_BASE + 8'(k);
            end
         end
      end else if (flt_trip_path) begin
         nxt_fault = FC_TRIP;
      end else if (power_reset) begin
         nxt_fault = FC_POWER;
      end
   end
   assign fault_perm = nxt_fault != FC_NONE;

   // fault code latches: it is repair information, kept until reset
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         fault_num_ff <= FC_NONE;
         fault_lead_ff <= 4'h0;
      end else if (fault_perm && fault_num_ff == FC_NONE) begin
         fault_num_ff <= nxt_fault;
         fault_lead_ff <= FC_LEAD_DIGIT;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irf_cnt_ff <= '0;
         internal_fault_indicator_ff <= 1'b0;
         supervision_out_ff <= 1'b0;
      end else if (fault_num_ff != FC_NONE) begin
         if (irf_cnt_ff < IRF_DELAY) begin
            irf_cnt_ff <= irf_cnt_ff + 8'h01;
         end else begin
            internal_fault_indicator_ff <= 1'b1;
            supervision_out_ff <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rsp_valid_ff <= 1'b0;
         rsp_data_ff <= '0;
         rsp_err_ff <= 1'b0;
      end else begin
         rsp_valid_ff <= cmd_valid;
         rsp_err_ff <= 1'b0;
         rsp_data_ff <= '0;
         if (cmd_valid) begin
            case (cmd_code)
               RRA_CMD_READ_EV:
                  rsp_data_ff <= ev_full_ff ? ev_reg_ff : '0;
               RRA_CMD_REREAD_EV: rsp_data_ff <= ev_last_ff;
               RRA_CMD_READ_STAT: rsp_data_ff <= 32'(status_ff);
               RRA_CMD_READ_SET: begin
                  if (idx_ok) begin
                     rsp_data_ff <= 32'(set_mem[cmd_group][cmd_index]);
                  end else begin
                     rsp_err_ff <= 1'b1;
                  end
               end
               RRA_CMD_READ_FAULT: rsp_data_ff <= 32'(fault_num_ff);
               RRA_CMD_WRITE_SET: rsp_err_ff <= !rem_ok;
               RRA_CMD_CHG_PWD: rsp_err_ff <= !pwd_open_ff;
               RRA_CMD_FORMAT: rsp_err_ff <= !fmt_ok;
               RRA_CMD_CLR_STAT: rsp_err_ff <= cmd_wdata != 16'h0000;
               RRA_CMD_OPEN_PWD: rsp_err_ff <= 1'b0;
               default: rsp_err_ff <= 1'b1;
            endcase
         end
      end
   end

   chk_write_gated: assert property (@(posedge sys_clk) disable iff (srst)
      rem_wr && !pwd_open_ff |=> rsp_err_ff)
      else $error("setting write accepted while password closed");
   chk_range_keep: assert property (@(posedge sys_clk) disable iff (srst)
      rem_wr && cmd_wdata > SET_MAX |=> rsp_err_ff)
      else $error("out of range write not refused");
   chk_read_once: assert property (@(posedge sys_clk) disable iff (srst)
      take_read && !ev_valid |=> !ev_full_ff)
      else $error("event stayed after read");
   chk_reread_same: assert property (@(posedge sys_clk) disable iff (srst)
      take_read ##1 (cmd_valid && cmd_code == RRA_CMD_REREAD_EV)
      |=> rsp_data_ff == $past(rsp_data_ff))
      else $error("re-read differs from last read");
   chk_ovf_flag: assert property (@(posedge sys_clk) disable iff (srst)
      ev_valid && ev_full_ff && !take_read |=> status_ff[1])
      else $error("overflow not flagged");
   chk_irf_delay: assert property (@(posedge sys_clk) disable iff (srst)
      $rose(fault_lead_ff == FC_LEAD_DIGIT)
      |-> ##[1:40] internal_fault_indicator_ff)
      else $error("indicator late");
   chk_adc_code: assert property (@(posedge sys_clk) disable iff (srst)
      flt_adc && fault_num_ff == FC_NONE |=> fault_num_ff == FC_ADC)
      else $error("converter fault code wrong");
   chk_low_code: assert property (@(posedge sys_clk) disable iff (srst)
      !flt_adc && ref_fault == 2'h1 && ref_mult == 2'h0
      && fault_num_ff == FC_NONE |=> fault_num_ff == FC_LOW_X1)
      else $error("reference low code wrong");
   chk_stat_reset: assert property (@(posedge sys_clk) disable iff (srst)
      auto_reset |=> status_ff[0])
      else $error("auto reset not flagged");
   cov_read_reread: cover property (@(posedge sys_clk) disable iff (srst)
      take_read ##1 (cmd_valid && cmd_code == RRA_CMD_REREAD_EV));
   cov_write_ok: cover property (@(posedge sys_clk) disable iff (srst)
      rem_ok);
   cov_fault_lit: cover property (@(posedge sys_clk) disable iff (srst)
      $rose(internal_fault_indicator_ff));
   cov_overflow: cover property (@(posedge sys_clk) disable iff (srst)
      $rose(status_ff[1]));
endmodule : rra_core

/* File: sim/rra_dc_model.sv */
// data communicator model that drives the remote command port
// assumes the core answers one cycle after the edge that takes a command
`timescale 1ns/1ps
module rra_dc_model
   import rra_pkg::*;
(
   input wire logic sys_clk,
   output logic cmd_valid,
   output rra_cmd_e cmd_code,
   output logic [1:0] cmd_group,
   output logic [3:0] cmd_index,
   output logic [15:0] cmd_wdata,
   input wire logic rsp_valid_ff,
   input wire logic [31:0] rsp_data_ff,
   input wire logic rsp_err_ff
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = RRA_CMD_NONE;
      cmd_group = 2'h0;
      cmd_index = 4'h0;
      cmd_wdata = 16'h0000;
   end
   // released data lines toggle so a stale value is never trusted
   task automatic xfer(input rra_cmd_e c, input logic [1:0] g,
                       input logic [3:0] i, input logic [15:0] w,
                       output logic [31:0] d, output logic e);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_group <= g;
      cmd_index <= i;
      cmd_wdata <= w;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      cmd_code <= RRA_CMD_NONE;
      cmd_wdata <= ~w;
      @(posedge sys_clk);
      d = rsp_data_ff;
      // a missing answer shows up as an unknown error flag
      e = rsp_valid_ff ? rsp_err_ff : 1'bx;
   endtask : xfer
   // read and re-read back to back, strobe held high across both
   task automatic read_reread(output logic [31:0] d1,
                              output logic [31:0] d2);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd_code <= RRA_CMD_READ_EV;
      @(posedge sys_clk);
      cmd_code <= RRA_CMD_REREAD_EV;
      @(posedge sys_clk);
      d1 = rsp_data_ff;
      cmd_valid <= 1'b0;
      cmd_code <= RRA_CMD_NONE;
      @(posedge sys_clk);
      d2 = rsp_data_ff;
   endtask : read_reread
   task automatic fetch_events(output logic [31:0] d, output logic e);
      xfer(RRA_CMD_READ_EV, 2'h0, 4'h0, 16'h0000, d, e);
   endtask : fetch_events
   task automatic clear_status(output logic e);
      logic [31:0] d;
      xfer(RRA_CMD_CLR_STAT, 2'h0, 4'h0, 16'h0000, d, e);
   endtask : clear_status
   task automatic open_pwd(input logic [15:0] w, output logic e);
      logic [31:0] d;
      xfer(RRA_CMD_OPEN_PWD, 2'h0, 4'h0, w, d, e);
   endtask : open_pwd
endmodule : rra_dc_model

/* File: sim/tb.sv */
// self-checking bench for the remote access and fault report core
// assumes the data communicator model drives the command port
`timescale 1ns/1ps
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin \
   fail_count++; $display("wrong value %s exp %0h got %0h", n, x, g); end end
module tb
   import rra_pkg::*;
;
   typedef struct packed {logic [13:0] f; logic [7:0] num;} rra_row_s;
   logic sys_clk, srst, cmd_valid, local_wr, ev_valid, auto_reset;
   rra_cmd_e cmd_code;
   logic [1:0] cmd_group, local_group, ref_fault, ref_mult, status_ff;
   logic [3:0] cmd_index, local_index, flt_par_mem, fault_lead_ff;
   logic [15:0] cmd_wdata, local_wdata;
   logic [31:0] ev_data, rsp_data_ff, d, d2;
   logic flt_trip_path, flt_rom, flt_ram, flt_par_key, flt_adc, power_reset;
   logic rsp_valid_ff, rsp_err_ff, pwd_open_ff, e;
   logic internal_fault_indicator_ff, supervision_out_ff;
   logic [7:0] fault_num_ff;
   int fail_count, cmp_count;
   // {adc, ref kind, multiplier, rom, ram, key, par[3:0], trip, power}
   rra_row_s rw [16] = '{
      '{14'h0001, 8'h01}, '{14'h0002, 8'h04}, '{14'h0004, 8'h33},
      '{14'h0008, 8'h34}, '{14'h0010, 8'h35}, '{14'h0020, 8'h36},
      '{14'h0040, 8'h38}, '{14'h0080, 8'h32}, '{14'h0100, 8'h1E},
      '{14'h0800, 8'hC3}, '{14'h0A00, 8'h83}, '{14'h0C00, 8'h43},
      '{14'h1000, 8'hCB}, '{14'h1200, 8'h8B}, '{14'h1400, 8'h4B},
      '{14'h2000, 8'hFD}};
   rra_core dut (.sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_group(cmd_group), .cmd_index(cmd_index),
      .cmd_wdata(cmd_wdata), .local_wr(local_wr),
      .local_group(local_group), .local_index(local_index),
      .local_wdata(local_wdata), .ev_valid(ev_valid), .ev_data(ev_data),
      .auto_reset(auto_reset), .flt_trip_path(flt_trip_path),
      .flt_rom(flt_rom), .flt_ram(flt_ram), .flt_par_mem(flt_par_mem),
      .flt_par_key(flt_par_key), .ref_fault(ref_fault),
      .ref_mult(ref_mult), .flt_adc(flt_adc), .power_reset(power_reset),
      .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff),
      .rsp_err_ff(rsp_err_ff), .pwd_open_ff(pwd_open_ff),
      .status_ff(status_ff),
      .internal_fault_indicator_ff(internal_fault_indicator_ff),
      .supervision_out_ff(supervision_out_ff),
      .fault_lead_ff(fault_lead_ff), .fault_num_ff(fault_num_ff));
   rra_dc_model p (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_group(cmd_group), .cmd_index(cmd_index),
      .cmd_wdata(cmd_wdata), .rsp_valid_ff(rsp_valid_ff),
      .rsp_data_ff(rsp_data_ff), .rsp_err_ff(rsp_err_ff));
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic do_reset(input int n);
      @(posedge sys_clk);
      srst <= 1'b1;
      {flt_adc, ref_fault, ref_mult, flt_rom, flt_ram, flt_par_key,
       flt_par_mem, flt_trip_path, power_reset} <= 14'h0000;
      repeat (n) @(posedge sys_clk);
      srst <= 1'b0;
   endtask : do_reset
   task automatic send_ev(input logic [31:0] v);
      @(posedge sys_clk);
      ev_valid <= 1'b1;
      ev_data <= v;
      @(posedge sys_clk);
      ev_valid <= 1'b0;
      ev_data <= ~v;
   endtask : send_ev
   initial begin
      {srst, local_wr, ev_valid, auto_reset} = 4'h8;
      {local_group, local_index, local_wdata, ev_data} = '0;
      do_reset(16);
      for (int k = 0; k < 16; k++) begin
         do_reset(2);
         @(posedge sys_clk);
         {flt_adc, ref_fault, ref_mult, flt_rom, flt_ram, flt_par_key,
          flt_par_mem, flt_trip_path, power_reset} <= rw[k].f;
         repeat (2) @(posedge sys_clk);
         #1;
         `CHK("fnum",rw[k].num,fault_num_ff)
         `CHK("lead", 4'h1, fault_lead_ff)
         repeat (30) @(posedge sys_clk);
         #1;
         `CHK("irf", 2'h3, {internal_fault_indicator_ff,
            supervision_out_ff})
         p.xfer(RRA_CMD_READ_FAULT, 2'h0, 4'h0, 16'h0000, d, e);
         `CHK("rd_fault", 32'(rw[k].num), d)
      end
      do_reset(2);
      p.xfer(RRA_CMD_CHG_PWD, 2'h0, 4'h0, 16'h0005, d, e);
      `CHK("chg_closed", 1'b1, e)
      p.xfer(RRA_CMD_WRITE_SET, 2'h1, 4'h3, 16'h0005, d, e);
      `CHK("wr_closed", 1'b1, e)
      p.open_pwd(16'h0001, e);
      `CHK("pwd", 2'h1, {e, pwd_open_ff})
      for (int g = 0; g < 3; g++) begin
         p.xfer(RRA_CMD_WRITE_SET, 2'(g), 4'hD, 16'h03E7, d, e);
         `CHK("wr", 1'b0, e)
         p.xfer(RRA_CMD_WRITE_SET, 2'(g), 4'hD, 16'h03E8, d, e);
         `CHK("wr_range", 1'b1, e)
         p.xfer(RRA_CMD_READ_SET, 2'(g), 4'hD, 16'h0000, d, e);
         `CHK("rd_set", 32'h03E7, d)
      end
      p.xfer(RRA_CMD_WRITE_SET, 2'h0, 4'hE, 16'h0001, d, e);
      `CHK("wr_idx", 1'b1, e)
      @(posedge sys_clk);
      {local_wr, local_group, local_index, local_wdata} <= {7'h4D, 16'h03E8};
      @(posedge sys_clk);
      local_wr <= 1'b0;
      p.xfer(RRA_CMD_READ_SET, 2'h0, 4'hD, 16'h0000, d, e);
      `CHK("local_range", 32'h03E7, d)
      @(posedge sys_clk);
      {local_wr, local_wdata} <= {1'b1, 16'h0010};
      @(posedge sys_clk);
      local_wr <= 1'b0;
      p.xfer(RRA_CMD_READ_SET, 2'h0, 4'hD, 16'h0000, d, e);
      `CHK("local_wr", 32'h0010, d)
      send_ev(32'hA5A50001);
      p.fetch_events(d, e);
      `CHK("ev", 32'hA5A50001, d)
      repeat (2) begin
         p.xfer(RRA_CMD_REREAD_EV, 2'h0, 4'h0, 16'h0000, d, e);
         `CHK("reread", 32'hA5A50001, d)
      end
      p.fetch_events(d, e);
      `CHK("ev_once", 32'h0, d)
      send_ev(32'h1);
      send_ev(32'h2);
      p.fetch_events(d, e);
      `CHK("ev_kept", 32'h1, d)
      `CHK("ovf", 2'h2, status_ff)
      send_ev(32'h5A5A0003);
      p.read_reread(d, d2);
      `CHK("rd_pair", 32'h5A5A0003, d)
      `CHK("reread_pair", 32'h5A5A0003, d2)
      @(posedge sys_clk);
      auto_reset <= 1'b1;
      @(posedge sys_clk);
      auto_reset <= 1'b0;
      p.xfer(RRA_CMD_READ_STAT, 2'h0, 4'h0, 16'h0000, d, e);
      `CHK("stat", 32'h3, d)
      p.clear_status(e);
      `CHK("clr", 2'h0, status_ff)
      `CHK("clr_err", 1'b0, e)
      p.xfer(RRA_CMD_CHG_PWD, 2'h0, 4'h0, 16'h0007, d, e);
      `CHK("chg", 1'b0, e)
      p.xfer(RRA_CMD_FORMAT, 2'h0, 4'h0, 16'h0003, d, e);
      `CHK("fmt_bad", 1'b1, e)
      p.xfer(RRA_CMD_FORMAT, 2'h0, 4'h0, 16'h0002, d, e);
      `CHK("fmt", 1'b0, e)
      p.xfer(RRA_CMD_CHG_PWD, 2'h0, 4'h0, 16'h0000, d, e);
      `CHK("close", 1'b0, pwd_open_ff)
      p.xfer(RRA_CMD_FORMAT, 2'h0, 4'h0, 16'h0002, d, e);
      `CHK("fmt_closed", 1'b1, e)
      p.open_pwd(16'h0001, e);
      `CHK("pwd_old", 1'b0, pwd_open_ff)
      p.open_pwd(16'h0007, e);
      `CHK("pwd_new", 1'b1, pwd_open_ff)
      print_verdict;
   end
   // about 750 cycles of tests; this is a generous margin
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      print_verdict;
   end
endmodule : tb
